// ### sci_defines.svh
// Constants of the serial controller interrupt and host access block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SCI_DEFINES_SVH
`define SCI_DEFINES_SVH

// Indirect register indices
`define SCI_R_PTR       4'h0
`define SCI_R_SPECIAL   4'h1
`define SCI_R_VECTOR    4'h2
`define SCI_R_PENDING   4'h3
`define SCI_W_IRQCTL    4'h1
`define SCI_W_MASTER    4'h9
`define SCI_R_MISC      4'ha
`define SCI_R_DIVLO     4'hc
`define SCI_R_DIVHI     4'hd
`define SCI_W_MISCCTL   4'he
`define SCI_R_EXTEN     4'hf

// Pointer register fields
`define SCI_PTR_HI      3
`define SCI_PTR_CLR_MSB 4
`define SCI_CMD_MSB     5
`define SCI_CMD_LSB     3
`define SCI_CMD_RST_EXT 3'h2
`define SCI_CMD_ARM_RX  3'h4
`define SCI_CMD_RST_TX  3'h5
`define SCI_CMD_ERR_RST 3'h6
`define SCI_CMD_RST_IUS 3'h7

// Interrupt/handshake control fields
`define SCI_C1_EXT_IE   0
`define SCI_C1_TX_IE    1
`define SCI_C1_PAR_SP   2
`define SCI_C1_RXM_LSB  3
`define SCI_C1_WR_ONRX  5
`define SCI_C1_WR_REQ   6
`define SCI_C1_WR_EN    7
`define SCI_RXM_OFF     2'h0
`define SCI_RXM_FIRST   2'h1
`define SCI_RXM_ALL     2'h2

// Master control fields and misc control
`define SCI_M_VIS       0
`define SCI_M_MIE       3
`define SCI_MC_LOOP     4

// Base status bit positions (also ext enable positions)
`define SCI_S_RXAV      0
`define SCI_S_BRGZ      1
`define SCI_S_TXEMPTY   2
`define SCI_EXT_MASK    8'hfa

// Source slots: channel A receive is slot 0 (highest)
`define SCI_NSRC        6
`define SCI_VST_NONE    3'h3
`define SCI_RST_VAL     8'h00

`endif

// ### sci_pkg.sv
// Types shared by the serial controller interrupt and host access block.
// Assumes sci_defines.svh is reachable by bare name.
`include "sci_defines.svh"

package sci_pkg;

    // Events and data from one channel's serial engine, same clock
    typedef struct packed {
        logic       rx_char;
        logic [7:0] rx_data;
        logic       overrun;
        logic       frame_err;
        logic       end_frame;
        logic       parity_err;
        logic       tx_empty;
        logic       underrun;
        logic       brg_zero;
        logic       brk_abort;
        logic       txd;
    } sci_ch_ev_t;

    // Pin levels of one channel, outside the clock domain
    typedef struct packed {
        logic cts;
        logic carrier_detect_in;
        logic sync;
        logic rxd;
    } sci_ch_pin_t;

endpackage : sci_pkg

// ### sci_core.sv
// Interrupt structure, daisy chain, indirect register access, block
// transfer handshake and local loopback of a dual-channel serial
// controller. Host strobes are synchronous to i_clk; the daisy-chain
// input and per-channel pins are asynchronous and are synchronised here.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`include "sci_defines.svh"
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Loopback ties transmit to receive, echoes pin
// - Loopback ignores enables, keeps their interrupts
// - Status bits 7:3 latched while external pending; two transfer-need bits
// - One pending register covers both channels
// - Acknowledge returns shared vector, readable both channels
// - Three status bits; channel B read modified
// - Six sources, each needs enable and master
// - Source enable bits never read back
// - No pending set while source disabled
// - Request low when pending and chain in high
// - In-service blocks lower sources and chain out
// - Acknowledge sets in-service if chain in high
// - A over B; receive, transmit, external
// - Transmit empty interrupt needs prior write
// - Three receive interrupt modes
// - Special conditions set receive pending and change vector status
// - First-char mode allows specials after first
// - External causes: pins, underrun, zero, break
// - Abort or end-of-poll interrupts on both edges
// - Wait/request line, wait or DMA request
// - Data registers direct, channel select high A
// - Indirect access clears pointer bits 4:0
module sci_core
    import sci_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // Host register port
    input  wire logic              i_data_cmd,
    input  wire logic              i_chan_a,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    input  wire logic [7:0]        i_wdata,
    output logic      [7:0]        o_rdata,
    // Interrupt chain
    input  wire logic              i_irq_acknowledge_in,
    input  wire logic              i_chain_enable_in,
    output logic                   o_chain_enable_out,
    output logic                   o_irq_o,
    output logic                   o_irq_oe_n,
    // Block transfer handshake, one per channel, index 1 is A
    output logic      [1:0]        o_wait_req_n,
    // Serial engine side
    input  wire sci_ch_ev_t [1:0]  i_ev,
    input  wire sci_ch_pin_t [1:0] i_pin,
    output logic      [1:0]        o_rxd_int,
    output logic      [1:0]        o_txd_pin,
    output logic      [1:0]        o_tx_enable,
    output logic      [1:0]        o_rx_enable
);

    // lowest set slot is the highest priority
    function automatic logic [2:0] sci_first(input logic [5:0] v);
        logic [2:0] r;
        r = 3'h7;
        for (int k = `SCI_NSRC - 1; k >= 0; k--)
        begin
            if (v[k])
                r = 3'(k);
        end
        return r;
    endfunction : sci_first

    // Mask of this slot and every higher-numbered, lower-priority one
    function automatic logic [5:0] sci_upto(input logic [2:0] s);
        return 6'h3f << s;
    endfunction : sci_upto

    // Pointer decode
    function automatic logic [3:0] sci_reg_idx(input logic [7:0] p);
        logic hi;
        hi = p[`SCI_PTR_HI] & ~p[6] & ~p[5];
        return {hi, p[2:0]};
    endfunction : sci_reg_idx

    // Chain input pin synchroniser
    logic       chain_s1_q;
    logic       chain_s2_q;
    logic [7:0] ptr_q;
    logic [7:0] vec_q;
    logic [7:0] master_q;
    wire  [5:0] ip;
    logic [5:0] ius_q;
    wire  [5:0] ie;
    wire  [1:0] special;
    logic [7:0] rd_d;
    logic [7:0] rd_q;

    wire  [3:0] idx       = sci_reg_idx(ptr_q);
    wire        ack_rd    = i_rd_stb & i_irq_acknowledge_in;
    wire        cmd_wr    = i_wr_stb & ~i_data_cmd & ~i_irq_acknowledge_in;
    wire        cmd_rd    = i_rd_stb & ~i_data_cmd & ~i_irq_acknowledge_in;
    wire        ptr_wr    = cmd_wr & (idx == `SCI_R_PTR);
    wire  [2:0] cmd       = i_wdata[`SCI_CMD_MSB:`SCI_CMD_LSB];
    wire        master_irq_enable       = master_q[`SCI_M_MIE];

    // Slots below the highest in-service one are held off
    wire  [5:0] ius_mask  = (ius_q == 6'h0) ? 6'h0 :
                            sci_upto(sci_first(ius_q));
    wire  [5:0] elig      = ip & ie & ~ius_mask & ~ius_q;
    wire  [2:0] top_src   = sci_first(elig);
    wire        any_req   = master_irq_enable & chain_s2_q & (elig != 6'h0);
    wire  [2:0] top_ius   = sci_first(ius_q);
    wire        ack_hit   = ack_rd & any_req;

    // Vector status code from the highest eligible source
    logic [2:0] vst;
    always_comb
    begin
        case (top_src)
            3'h0:    vst = special[1] ? 3'h7 : 3'h6;
            3'h1:    vst = 3'h4;
            3'h2:    vst = 3'h5;
            3'h3:    vst = special[0] ? 3'h3 : 3'h2;
            3'h4:    vst = 3'h0;
            3'h5:    vst = 3'h1;
            default: vst = `SCI_VST_NONE;
        endcase
    end

    wire  [7:0] vec_mod   = {vec_q[7:4], vst, vec_q[0]};
    wire  [7:0] vec_ack   = master_q[`SCI_M_VIS] ? vec_mod : vec_q;

    // open drain request, enable low while driving
    assign o_irq_o    = 1'b0;
    assign o_irq_oe_n = ~any_req;
    // in-service or acknowledge in progress blocks the chain
    assign o_chain_enable_out = chain_s2_q & (ius_q == 6'h0) &
                                ~(i_irq_acknowledge_in & any_req);
    assign o_rdata    = rd_q;

    always_ff @(posedge i_clk)
    begin
        chain_s1_q <= i_chain_enable_in;
        chain_s2_q <= chain_s1_q;
    end

    // Pointer and shared registers
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            ptr_q    <= `SCI_RST_VAL;
            vec_q    <= `SCI_RST_VAL;
            master_q <= `SCI_RST_VAL;
        end
        else
        begin
            // pointer bit 3 selects the upper bank while bits 6 and 5 are low
            if (ptr_wr)
                ptr_q <= i_wdata;
            // one indirect access returns pointer to base
            else if ((cmd_wr | cmd_rd) & (idx != `SCI_R_PTR))
                ptr_q <= {ptr_q[7:5], 5'h00};
            if (cmd_wr & (idx == `SCI_R_VECTOR))
                vec_q <= i_wdata;
            if (cmd_wr & (idx == `SCI_W_MASTER))
                master_q <= i_wdata;
        end
    end

    // In-service bits
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            ius_q <= 6'h0;
        else
        begin
            // only when this device owns the acknowledge
            if (ack_hit)
                ius_q[top_src] <= 1'b1;
            else if (ptr_wr & (cmd == `SCI_CMD_RST_IUS) & (ius_q != 6'h0))
                ius_q[top_ius] <= 1'b0;
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            rd_q <= `SCI_RST_VAL;
        else if (i_rd_stb)
            rd_q <= rd_d;
    end

    // Per-channel logic, g = 1 is channel A
    logic [7:0] rr_ch [1:0];
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            localparam logic [2:0] BASE = (g == 1) ? 3'h0 : 3'h3;
            logic       cts_s1_q, cts_s2_q, dcd_s1_q, dcd_s2_q;
            logic       syn_s1_q, syn_s2_q, rxd_s1_q, rxd_s2_q;
            logic [7:0] ctl_q, misc_q, dlo_q, dhi_q, exten_q, lat_q;
            logic [7:0] rxbuf_q, err_q;
            logic       rx_av_q, tx_empty_q, tx_loaded_q, arm_q;
            logic       rx_ip_q, tx_ip_q, ext_ip_q;

            wire sel    = (i_chan_a == (g == 1));
            wire c_wr   = cmd_wr & sel;
            wire d_wr   = i_wr_stb & i_data_cmd & sel &
                          ~i_irq_acknowledge_in;
            wire d_rd   = i_rd_stb & i_data_cmd & sel &
                          ~i_irq_acknowledge_in;
            wire [1:0] rxm = ctl_q[`SCI_C1_RXM_LSB +: 2];
            wire loop   = misc_q[`SCI_MC_LOOP];

            wire rx_ie  = (rxm != `SCI_RXM_OFF);
            wire tx_ie  = ctl_q[`SCI_C1_TX_IE];
            wire ext_ie = ctl_q[`SCI_C1_EXT_IE];

            wire spec_ev = i_ev[g].overrun | i_ev[g].frame_err |
                           i_ev[g].end_frame |
                           (i_ev[g].parity_err & ctl_q[`SCI_C1_PAR_SP]);
            wire chr_set = i_ev[g].rx_char &
                           ((rxm == `SCI_RXM_ALL) |
                            ((rxm == `SCI_RXM_FIRST) & arm_q));
            // specials in first-char mode once it has fired
            wire sp_set  = spec_ev & rx_ie &
                           ~((rxm == `SCI_RXM_FIRST) & arm_q);
            // empty counts only after a character was loaded
            wire tx_set  = i_ev[g].tx_empty & tx_loaded_q & tx_ie;

            // live external status, pins are synchronised
            wire [7:0] live = {i_ev[g].brk_abort, i_ev[g].underrun,
                               cts_s2_q, syn_s2_q, dcd_s2_q,
                               1'b0, i_ev[g].brg_zero, 1'b0};
            // any change of an enabled external status level, both edges
            wire ext_chg = ((live ^ lat_q) & exten_q &
                            `SCI_EXT_MASK) != 8'h0;
            wire ext_set = ext_chg & ext_ie;
            wire rst_ext = c_wr & ptr_wr & (cmd == `SCI_CMD_RST_EXT);

            // base status, receive available and transmit empty
            wire [7:0] st0 = {lat_q[7:3], tx_empty_q,
                              live[`SCI_S_BRGZ], rx_av_q};

            always_ff @(posedge i_clk)
            begin
                cts_s1_q <= i_pin[g].cts;
                cts_s2_q <= cts_s1_q;
                dcd_s1_q <= i_pin[g].carrier_detect_in;
                dcd_s2_q <= dcd_s1_q;
                syn_s1_q <= i_pin[g].sync;
                syn_s2_q <= syn_s1_q;
                rxd_s1_q <= i_pin[g].rxd;
                rxd_s2_q <= rxd_s1_q;
            end

            // Channel registers written through the pointer
            always_ff @(posedge i_clk)
            begin
                if (i_srst)
                begin
                    ctl_q   <= `SCI_RST_VAL;
                    misc_q  <= `SCI_RST_VAL;
                    dlo_q   <= `SCI_RST_VAL;
                    dhi_q   <= `SCI_RST_VAL;
                    exten_q <= `SCI_RST_VAL;
                end
                else if (c_wr)
                begin
                    if (idx == `SCI_W_IRQCTL)
                        ctl_q <= i_wdata;
                    if (idx == `SCI_R_DIVLO)
                        dlo_q <= i_wdata;
                    if (idx == `SCI_R_DIVHI)
                        dhi_q <= i_wdata;
                    if (idx == `SCI_W_MISCCTL)
                        misc_q <= i_wdata;
                    if (idx == `SCI_R_EXTEN)
                        exten_q <= i_wdata;
                end
            end

            // Data paths and transfer status; set wins over clear except in arm_q, where a first-mode character wins over the arm command
            always_ff @(posedge i_clk)
            begin
                if (i_srst)
                begin
                    rxbuf_q     <= `SCI_RST_VAL;
                    err_q       <= `SCI_RST_VAL;
                    rx_av_q     <= 1'b0;
                    tx_empty_q  <= 1'b1;
                    tx_loaded_q <= 1'b0;
                    arm_q       <= 1'b1;
                end
                else
                begin
                    if (i_ev[g].rx_char)
                        rxbuf_q <= i_ev[g].rx_data;
                    rx_av_q <= i_ev[g].rx_char | (rx_av_q & ~d_rd);
                    tx_empty_q <= i_ev[g].tx_empty | (tx_empty_q & ~d_wr);
                    tx_loaded_q <= d_wr | (tx_loaded_q & ~i_ev[g].tx_empty);
                    if (i_ev[g].rx_char & (rxm == `SCI_RXM_FIRST))
                        arm_q <= 1'b0;
                    else if (c_wr & ptr_wr & (cmd == `SCI_CMD_ARM_RX))
                        arm_q <= 1'b1;
                    err_q <= {i_ev[g].end_frame, i_ev[g].frame_err,
                              i_ev[g].overrun, i_ev[g].parity_err, 4'h0}
                             | (err_q & ((c_wr & ptr_wr &
                                 (cmd == `SCI_CMD_ERR_RST)) ?
                                8'h0 : 8'hff));
                end
            end

            // every set term is gated by its enable
            always_ff @(posedge i_clk)
            begin
                if (i_srst)
                begin
                    rx_ip_q  <= 1'b0;
                    tx_ip_q  <= 1'b0;
                    ext_ip_q <= 1'b0;
                    lat_q    <= `SCI_RST_VAL;
                end
                else
                begin
                    rx_ip_q  <= rx_ie & (chr_set | sp_set |
                                (rx_ip_q & ~d_rd & ~(c_wr & ptr_wr &
                                 (cmd == `SCI_CMD_ERR_RST))));
                    tx_ip_q  <= tx_ie & (tx_set | (tx_ip_q & ~d_wr &
                                ~(c_wr & ptr_wr &
                                  (cmd == `SCI_CMD_RST_TX))));
                    ext_ip_q <= ext_ie & (ext_set | (ext_ip_q & ~rst_ext));
                    // Status freezes while an external interrupt waits
                    if (~ext_ip_q | rst_ext)
                        lat_q <= live;
                end
            end

            assign ip[BASE]        = rx_ip_q;
            assign ip[BASE + 3'h1] = tx_ip_q;
            assign ip[BASE + 3'h2] = ext_ip_q;
            assign ie[BASE]        = rx_ie;
            assign ie[BASE + 3'h1] = tx_ie;
            assign ie[BASE + 3'h2] = ext_ie;
            assign special[g]      = err_q[7:5] != 3'h0 |
                                     (err_q[4] & ctl_q[`SCI_C1_PAR_SP]);

            // internal transmit feeds receive, pin echoed out
            assign o_rxd_int[g]   = loop ? i_ev[g].txd : rxd_s2_q;
            assign o_txd_pin[g]   = loop ? rxd_s2_q : i_ev[g].txd;
            // pins stop acting as enables in loopback
            assign o_tx_enable[g] = loop | cts_s2_q;
            assign o_rx_enable[g] = loop | dcd_s2_q;

            // request when ready, wait while not ready
            wire ready = ctl_q[`SCI_C1_WR_ONRX] ? rx_av_q : tx_empty_q;
            assign o_wait_req_n[g] = ~(ctl_q[`SCI_C1_WR_EN] &
                                       (ctl_q[`SCI_C1_WR_REQ] ? ready :
                                        ~ready));

            // source enable bits have no read path
            always_comb
            begin
                if (i_data_cmd)
                    rr_ch[g] = rxbuf_q;
                else
                begin
                    case (idx)
                        `SCI_R_PTR:     rr_ch[g] = st0;
                        `SCI_R_SPECIAL: rr_ch[g] = err_q;
                        `SCI_R_VECTOR:  rr_ch[g] = (g == 1) ? vec_q :
                                                    vec_mod;
                        // all six pending bits, channel A only
                        `SCI_R_PENDING: rr_ch[g] = (g == 1) ?
                                           {2'h0, ip[0], ip[1], ip[2],
                                            ip[3], ip[4], ip[5]} : 8'h0;
                        `SCI_R_MISC:    rr_ch[g] = {7'h0, loop};
                        `SCI_R_DIVLO:   rr_ch[g] = dlo_q;
                        `SCI_R_DIVHI:   rr_ch[g] = dhi_q;
                        `SCI_R_EXTEN:   rr_ch[g] = exten_q;
                        default:        rr_ch[g] = 8'h0;
                    endcase
                end
            end
        end
    endgenerate

    // channel select high reads channel A
    always_comb
    begin
        if (i_irq_acknowledge_in)
            rd_d = ack_hit ? vec_ack : 8'h0;
        else
            rd_d = i_chan_a ? rr_ch[1] : rr_ch[0];
    end

endmodule : sci_core

`default_nettype wire

// ### sci_core_chk.sv
// Assertions on the serial controller interrupt block's ports.
// Assumes the chain input and pins pass 2-FF synchronisers.
`timescale 1ns/1ns
`default_nettype none
module sci_core_chk
    import sci_pkg::*;
(
    // Clock and reset
    input wire logic              i_clk,
    input wire logic              i_srst,
    // Host side
    input wire logic              i_rd_stb,
    input wire logic              i_irq_acknowledge_in,
    input wire logic              i_chain_enable_in,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_chain_enable_out,
    input wire logic              o_irq_o,
    input wire logic              o_irq_oe_n,
    // Serial side
    input wire sci_ch_pin_t [1:0] i_pin,
    input wire logic [1:0]        o_tx_enable
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence ack_held;
        i_irq_acknowledge_in && $past(i_irq_acknowledge_in);
    endsequence
    sequence requesting;
        !o_irq_oe_n;
    endsequence

    irq_low_drive_a: assert property (o_irq_o == 1'b0)
        else $error("request value not low");
    rdata_hold_a: assert property ($changed(o_rdata) |-> $past(i_rd_stb))
        else $error("read data moved without read");
    reset_clean_a: assert property
        ($fell(i_srst) |-> o_rdata == 8'h00 && o_irq_oe_n)
        else $error("not clean after reset");
    chain_sync_a: assert property
        (o_chain_enable_out |-> $past(i_chain_enable_in, 2))
        else $error("chain out high with chain in low");
    req_gate_a: assert property
        (requesting |-> $past(i_chain_enable_in, 2))
        else $error("request with chain in low");
    ack_chain_a: assert property
        (ack_held ##0 requesting |-> !o_chain_enable_out)
        else $error("chain out high while acknowledged");
    ack_block_a: assert property
        (ack_held ##0 i_rd_stb ##0 requesting |=> !o_chain_enable_out)
        else $error("chain out high after acknowledge");
    tx_enable_a: assert property
        (!o_tx_enable[1] |-> !$past(i_pin[1].cts, 2))
        else $error("transmit disabled with send enable high");
endmodule : sci_core_chk

bind sci_core sci_core_chk sci_core_chk_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_rd_stb(i_rd_stb),
    .i_irq_acknowledge_in(i_irq_acknowledge_in),
    .i_chain_enable_in(i_chain_enable_in), .o_rdata(o_rdata),
    .o_chain_enable_out(o_chain_enable_out), .o_irq_o(o_irq_o),
    .o_irq_oe_n(o_irq_oe_n), .i_pin(i_pin), .o_tx_enable(o_tx_enable)
);
`default_nettype wire

// ### sci_host.sv
// Host CPU model driving the register port and acknowledge.
// Assumes its tasks are entered 1 ns after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module sci_host
(
    // Clock
    input  wire logic       i_clk,
    // Register port
    output logic            o_data_cmd,
    output logic            o_chan_a,
    output logic            o_wr_stb,
    output logic            o_rd_stb,
    output logic            o_ack,
    output logic [7:0]      o_wdata,
    input  wire logic [7:0] i_rdata,
    // Request pin
    input  wire logic       i_irq_oe_n,
    input  wire logic       i_irq_o,
    output logic            o_irq_line_n
);
    assign o_irq_line_n = i_irq_oe_n ? 1'b1 : i_irq_o;

    initial
    begin
        {o_data_cmd, o_chan_a, o_wr_stb, o_rd_stb, o_ack} = 5'h00;
        o_wdata = 8'h00;
    end

    task automatic wr(input logic dc, input logic a, input logic [7:0] d);
        o_data_cmd <= dc;
        o_chan_a   <= a;
        o_wdata    <= d;
        o_wr_stb   <= 1'b1;
        @(posedge i_clk);
        o_wr_stb   <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic dc, input logic a, input logic ak,
                      output logic [7:0] q);
        // acknowledge leads the read so chains settle
        if (ak)
        begin
            o_ack <= 1'b1;
            @(posedge i_clk);
            #1;
        end
        o_data_cmd <= dc;
        o_chan_a   <= a;
        o_rd_stb   <= 1'b1;
        @(posedge i_clk);
        o_rd_stb   <= 1'b0;
        o_ack      <= 1'b0;
        #1;
        q = i_rdata;
    endtask : rd
endmodule : sci_host
`default_nettype wire

// ### sci_core_tb.sv
// Self-checking bench for the serial controller interrupt block.
// Assumes channel A is index 1 of the per-channel arrays.
`timescale 1ns/1ns
`default_nettype none
module sci_core_tb
    import sci_pkg::*;
;
    localparam int EV_TXE = 4;
    localparam int EV_OVR = 8;
    localparam int EV_RX  = 17;
    logic              clk, srst, chain;
    sci_ch_ev_t [1:0]  ev;
    sci_ch_pin_t [1:0] pin;
    logic [31:0]       rnd;
    logic [7:0]        v, q;
    int                n_mismatch, tests_run;
    wire logic         dc, ca, ws, rs, ak, irq_o, oe_n, ceo, irq_n;
    wire logic [7:0]   wd, rdata;
    wire logic [1:0]   wrq, rxi, txp, txe, rxe;

    sci_core sci_core_inst (
        .i_clk(clk), .i_srst(srst), .i_data_cmd(dc), .i_chan_a(ca),
        .i_wr_stb(ws), .i_rd_stb(rs), .i_wdata(wd), .o_rdata(rdata),
        .i_irq_acknowledge_in(ak), .i_chain_enable_in(chain),
        .o_chain_enable_out(ceo), .o_irq_o(irq_o), .o_irq_oe_n(oe_n),
        .o_wait_req_n(wrq), .i_ev(ev), .i_pin(pin), .o_rxd_int(rxi),
        .o_txd_pin(txp), .o_tx_enable(txe), .o_rx_enable(rxe)
    );
    sci_host sci_host_inst (
        .i_clk(clk), .o_data_cmd(dc), .o_chan_a(ca), .o_wr_stb(ws),
        .o_rd_stb(rs), .o_ack(ak), .o_wdata(wd), .i_rdata(rdata),
        .i_irq_oe_n(oe_n), .i_irq_o(irq_o), .o_irq_line_n(irq_n)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Channel B vector carries source status in bits 3:1
    function automatic logic [7:0] vmod(input logic [7:0] x,
                                        input logic [2:0] st);
        return {x[7:4], st, x[0]};
    endfunction : vmod

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    task automatic do_reset();
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        #1;
    endtask : do_reset
    task automatic wri(input logic a, input logic [3:0] x, input logic [7:0] d);
        sci_host_inst.wr(1'b0, a, {4'h0, x});
        sci_host_inst.wr(1'b0, a, d);
    endtask : wri
    task automatic rdi(input logic a, input logic [3:0] x, input logic [7:0] e);
        sci_host_inst.wr(1'b0, a, {4'h0, x});
        sci_host_inst.rd(1'b0, a, 1'b0, q);
        check(q, e);
    endtask : rdi
    task automatic acki(input logic [7:0] e);
        sci_host_inst.rd(1'b0, 1'b1, 1'b1, q);
        check(q, e);
    endtask : acki
    task automatic pulse(input int c, input int b);
        ev[c][b] <= 1'b1;
        @(posedge clk);
        ev[c][b] <= 1'b0;
        #1;
    endtask : pulse
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is under two hundred cycles
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        {srst, chain, ev, pin} = {2'b11, 44'h0};
        {rnd, n_mismatch, tests_run} = {32'h2c79, 64'h0};
        do_reset();
        rdi(1'b1, 4'h0, 8'h04);
        rdi(1'b1, 4'h3, 8'h00);
        rnd = lfsr(rnd);
        v = rnd[7:0];
        wri(1'b0, 4'h2, v);
        rdi(1'b0, 4'h2, vmod(v, 3'h3));
        rdi(1'b1, 4'h2, v);
        sci_host_inst.wr(1'b0, 1'b1, 8'h2a);
        sci_host_inst.rd(1'b0, 1'b1, 1'b0, q);
        check(q, v);
        sci_host_inst.rd(1'b0, 1'b1, 1'b0, q);
        check(q, 8'h04);
        wri(1'b1, 4'h9, 8'h09);
        sci_host_inst.wr(1'b1, 1'b1, rnd[15:8]);
        pulse(1, EV_TXE);
        rdi(1'b1, 4'h3, 8'h00);
        wri(1'b1, 4'h1, 8'h02);
        rdi(1'b1, 4'h1, 8'h00);
        wri(1'b0, 4'h1, 8'h02);
        pulse(0, EV_TXE);
        rdi(1'b1, 4'h3, 8'h00);
        sci_host_inst.wr(1'b1, 1'b1, rnd[23:16]);
        sci_host_inst.wr(1'b1, 1'b0, rnd[31:24]);
        pulse(1, EV_TXE);
        pulse(0, EV_TXE);
        rdi(1'b1, 4'h3, 8'h12);
        check(irq_n, 1'b0);
        acki(vmod(v, 3'h4));
        check(ceo, 1'b0);
        check(irq_n, 1'b1);
        sci_host_inst.wr(1'b0, 1'b1, 8'h28);
        sci_host_inst.wr(1'b0, 1'b1, 8'h38);
        check(irq_n, 1'b0);
        chain <= 1'b0;
        settle();
        check(irq_n, 1'b1);
        acki(8'h00);
        chain <= 1'b1;
        settle();
        acki(vmod(v, 3'h0));
        for (int m = 1; m < 4; m++)
        begin
            do_reset();
            wri(1'b1, 4'h9, 8'h09);
            wri(1'b1, 4'h2, v);
            wri(1'b1, 4'h1, 8'(m << 3));
            pulse(1, EV_RX);
            rdi(1'b1, 4'h3, (m == 3) ? 8'h00 : 8'h20);
            if (m == 3)
                pulse(1, EV_OVR);
            acki(vmod(v, (m == 3) ? 3'h7 : 3'h6));
        end
        do_reset();
        wri(1'b1, 4'h9, 8'h09);
        wri(1'b1, 4'hf, 8'h20);
        wri(1'b1, 4'h1, 8'h01);
        pin[1].cts <= 1'b1;
        settle();
        rdi(1'b1, 4'h3, 8'h08);
        rdi(1'b1, 4'h0, 8'h24);
        wri(1'b1, 4'he, 8'h10);
        rdi(1'b1, 4'ha, 8'h01);
        sci_host_inst.wr(1'b0, 1'b1, 8'h10);
        repeat (8)
        begin
            rnd = lfsr(rnd);
            {ev[1].txd, pin[1].rxd, pin[1].cts} <= rnd[2:0];
            settle();
            check(rxi[1], rnd[2]);
            check(txp[1], rnd[1]);
            check(txe[1], 1'b1);
        end
        rdi(1'b1, 4'h3, 8'h08);
        do_reset();
        wri(1'b1, 4'h1, 8'he0);
        check(wrq[1], 1'b1);
        ev[1].rx_data <= rnd[10:3];
        pulse(1, EV_RX);
        check(wrq[1], 1'b0);
        sci_host_inst.rd(1'b1, 1'b1, 1'b0, q);
        check(q, rnd[10:3]);
        check(wrq[1], 1'b1);
        summarize();
    end
endmodule : sci_core_tb
`default_nettype wire
